// ===== hw/pom_pkg.sv
// Shared constants and types for the programmable output macrocell
`default_nettype none

package pom_pkg;

  // Configuration bit positions
  localparam int unsigned CFG_POL   = 0;
  localparam int unsigned CFG_COMB  = 1;
  localparam int unsigned CFG_FBSEL = 2;

  // Word offsets on the register bus
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_VERIFY = 4'h4;
  localparam logic [3:0] ADDR_PROG   = 4'h8;
  localparam logic [3:0] ADDR_REFUSE = 4'hc;

  // Status register fields
  localparam int unsigned ST_REG_Q    = 0;
  localparam int unsigned ST_PIN      = 1;
  localparam int unsigned ST_OE       = 2;
  localparam int unsigned ST_FB       = 3;
  localparam int unsigned ST_POR_DONE = 4;
  localparam int unsigned ST_LOCK     = 5;
  localparam int unsigned ST_DRIVE    = 6;

  // Verify register fields
  localparam int unsigned VF_CFG_LSB = 0;
  localparam int unsigned VF_SIG_LSB = 8;

  // Refusal flags, write one to clear
  localparam int unsigned RF_VERIFY = 0;
  localparam int unsigned RF_PROG   = 1;

  // Reset values
  localparam logic [31:0] PROG_RST   = 32'h0000_0000;
  localparam logic [1:0]  REFUSE_RST = 2'h0;

  // Power-up clear window, longest time so rounded down
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned POR_MAX_NS    = 5000;
  localparam int unsigned POR_CYC       = POR_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned POR_W         = $clog2(POR_CYC + 1);

  // Terms arriving from the logic array
  typedef struct packed {
    logic sum;
    logic oe;
    logic preset;
    logic clear;
  } pom_terms_t;

endpackage : pom_pkg

`default_nettype wire

// ===== hw/pom_dff.sv
// Macrocell D flip-flop with synchronous preset and asynchronous clear
`default_nettype none

module pom_dff (
  input  wire logic clk,
  input  wire logic clr_async,
  input  wire logic hold_clear,
  input  wire logic preset,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic q;
  } pom_dff_state_t;

  pom_dff_state_t s_q;
  pom_dff_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (hold_clear) begin
      s_d.q = 1'b0;
    end else if (preset) begin
      s_d.q = 1'b1;
    end else begin
      s_d.q = d;
    end
  end

  // clear acts at once, beats preset
  always_ff @(posedge clk or posedge clr_async) begin
    if (clr_async) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule : pom_dff

`default_nettype wire

// ===== hw/pom_macrocell.sv
// Output macrocell top with pin driver, feedback select and bus slave
//
// Contract
// - Feedback comes from the pin when combinatorial, or registered with feedback select.
// - With pin feedback the pin serves as input, output or bidirectional line.
// - Bits 0,0,0: registered, active low, register feedback.
// - Bits 0,0,1: registered, active high, register feedback.
// - Bits x,1,0: sum inverted to pin, no register, pin feedback.
// - Bits x,1,1: sum straight to pin, no register, pin feedback.
// - Bits 1,0,0: registered, active low, pin feedback.
// - Bits 1,0,1: registered, active high, pin feedback.
// - Flip-flop comes up cleared at power-up.
// - After power-up the pin level follows configured polarity.
// - Power-up clear completes within 5 us.
// - Once locked, verify and programming are refused for good.
// - Flip-flop captures the sum on each rising clock edge.
// - Preset term sets the flip-flop at the next rising edge.
// - Clear term zeroes the flip-flop at once and beats preset.
// - Register feedback is the inverted flip-flop output.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`default_nettype none

module pom_macrocell
  import pom_pkg::*;
#(
  parameter logic [2:0]  CFG        = 3'h0,
  parameter logic        LOCKED     = 1'b1,
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire pom_terms_t  terms,
  input  wire logic        clock_or_input_pin,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe,
  output logic             fb_o,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  // Elaboration checks
  if (POR_CYCLES < 1) begin : g_por_min
    $error("POR_CYCLES must be at least one");
  end
  if (POR_CYCLES >= (1 << POR_W)) begin : g_por_max
    $error("POR_CYCLES does not fit the counter");
  end
  // A longer window would break the power-up clear bound
  if (POR_CYCLES > POR_CYC) begin : g_por_bound
    $error("POR_CYCLES exceeds the power-up clear bound");
  end

  // Decoded configuration, never changes after build
  // fixed configuration
  localparam logic POL_HIGH = CFG[CFG_POL];
  localparam logic COMB     = CFG[CFG_COMB];
  localparam logic FB_PIN   = CFG[CFG_FBSEL];

  localparam logic USE_PIN_FB = COMB | FB_PIN;

  localparam logic PIN_RST = ~POL_HIGH;

  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);

  // Applies the configured output polarity
  function automatic logic drive_level(input logic v);
    drive_level = POL_HIGH ? v : ~v;
  endfunction : drive_level

  // Maps a bus address to one of the four words
  function automatic logic [3:0] word_sel(input logic [31:0] a);
    word_sel = {a[3:2], 2'b00};
  endfunction : word_sel

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'b00);
  endfunction : mapped

  typedef struct packed {
    logic [1:0]       pin_sync;
    logic [1:0]       ck_sync;
    logic [POR_W-1:0] por_cnt;
    logic             por_done;
    logic             pin_o;
    logic             pin_oe;
    logic             fb;
    logic             dph_wr;
    logic [31:0]      dph_addr;
    logic             hready;
    logic             hresp;
    logic [31:0]      hrdata;
    logic [31:0]      prog_data;
    logic [1:0]       refuse;
  } pom_state_t;

  localparam pom_state_t STATE_RST = '{
    pin_sync:  2'h0,
    ck_sync:   2'h0,
    por_cnt:   '0,
    por_done:  1'b0,
    pin_o:     PIN_RST,
    pin_oe:    1'b0,
    fb:        1'b0,
    dph_wr:    1'b0,
    dph_addr:  32'h0000_0000,
    hready:    1'b1,
    hresp:     1'b0,
    hrdata:    32'h0000_0000,
    prog_data: PROG_RST,
    refuse:    REFUSE_RST
  };

  pom_state_t s_q;
  pom_state_t s_d;

  logic reg_q;
  logic clr_async;
  logic hold_clear;
  logic pin_s;
  logic addr_ph;
  logic refuse_set_v;
  logic refuse_set_p;

  // Clear term goes straight to the flop clear; it must be glitch free
  // cleared at power-up
  assign clr_async  = rst | terms.clear;
  assign hold_clear = ~s_q.por_done;
  assign pin_s      = s_q.pin_sync[1];
  assign addr_ph    = hsel & htrans[1] & hready;

  pom_dff u_dff (
    .clk        (clk),
    .clr_async  (clr_async),
    .hold_clear (hold_clear),
    .preset     (terms.preset),
    .d          (terms.sum),
    .q          (reg_q)
  );

  always_comb begin
    s_d          = s_q;
    refuse_set_v = 1'b0;
    refuse_set_p = 1'b0;

    // Pins are outside the clock domain
    s_d.pin_sync = {s_q.pin_sync[0], pin_i};
    s_d.ck_sync  = {s_q.ck_sync[0], clock_or_input_pin};

    if (!s_q.por_done) begin
      if (s_q.por_cnt == POR_LAST) begin
        s_d.por_done = 1'b1;
      end else begin
        s_d.por_cnt = s_q.por_cnt + POR_W'(1);
      end
    end

    // Output path; registered mode shows the flop one edge later
    if (COMB) begin
      s_d.pin_o = drive_level(terms.sum);
    end else begin
      s_d.pin_o = drive_level(reg_q);
    end

    s_d.pin_oe = terms.oe;

    if (USE_PIN_FB) begin
      s_d.fb = pin_s;
    end else begin
      s_d.fb = ~reg_q;
    end

    // Data phase of a write
    s_d.dph_wr = 1'b0;
    // Unmapped writes must not alias onto a real word
    if (s_q.dph_wr && mapped(s_q.dph_addr)) begin
      case (word_sel(s_q.dph_addr))
        ADDR_PROG: begin
          if (LOCKED) begin
            refuse_set_p = 1'b1;
          end else begin
            s_d.prog_data = hwdata;
          end
        end
        ADDR_REFUSE: begin
          s_d.refuse = s_q.refuse & ~hwdata[1:0];
        end
        default: begin
          s_d.prog_data = s_d.prog_data;
        end
      endcase
    end

    // Address phase; read data computed after any pending write
    s_d.hready = 1'b1;
    s_d.hresp  = 1'b0;
    s_d.hrdata = 32'h0000_0000;
    if (addr_ph) begin
      s_d.dph_wr   = hwrite;
      s_d.dph_addr = haddr;
      if (!hwrite && mapped(haddr)) begin
        case (word_sel(haddr))
          ADDR_STATUS: begin
            s_d.hrdata[ST_REG_Q]    = reg_q;
            s_d.hrdata[ST_PIN]      = pin_s;
            s_d.hrdata[ST_OE]       = s_q.pin_oe;
            s_d.hrdata[ST_FB]       = s_q.fb;
            s_d.hrdata[ST_POR_DONE] = s_q.por_done;
            s_d.hrdata[ST_LOCK]     = LOCKED;
            s_d.hrdata[ST_DRIVE]    = s_q.pin_o;
          end
          ADDR_VERIFY: begin
            if (LOCKED) begin
              refuse_set_v = 1'b1;
            end else begin
              s_d.hrdata[VF_CFG_LSB +: 3]  = CFG;
              s_d.hrdata[VF_SIG_LSB +: 24] = s_d.prog_data[23:0];
            end
          end
          ADDR_PROG: begin
            if (!LOCKED) begin
              s_d.hrdata = s_d.prog_data;
            end
          end
          ADDR_REFUSE: begin
            s_d.hrdata[1:0] = s_d.refuse;
          end
          default: begin
            s_d.hrdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Set wins over a clear in the same cycle
    if (refuse_set_v) begin
      s_d.refuse[RF_VERIFY] = 1'b1;
    end
    if (refuse_set_p) begin
      s_d.refuse[RF_PROG] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_o     = s_q.pin_o;
  assign pin_oe    = s_q.pin_oe;
  assign fb_o      = s_q.fb;
  assign hreadyout = s_q.hready;
  assign hresp     = s_q.hresp;
  assign hrdata    = s_q.hrdata;

  // Clock pin level and hsize are accepted but carry no behaviour here
  logic unused_ok;
  assign unused_ok = s_q.ck_sync[1] ^ (^hsize) ^ (^haddr[1:0]);

endmodule : pom_macrocell

`default_nettype wire

// ===== bench/pom_macrocell_assertions.sv
// Port checks for the output macrocell
`default_nettype none
module pom_macrocell_chk
  import pom_pkg::*;
#(
  parameter logic [2:0]  CFG        = 3'h0,
  parameter logic        LOCKED     = 1'b1,
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire pom_terms_t  terms,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe,
  input wire logic        fb_o,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt_q;
  wire         run = cnt_q > POR_CYCLES + 1;
  // Saturates so the edge count since reset never wraps
  always_ff @(posedge clk or posedge rst)
    if (rst) cnt_q <= 0;
    else if (cnt_q < POR_CYCLES + 8) cnt_q <= cnt_q + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_follow: assert property (
    !$past(rst) |-> pin_oe == $past(terms.oe)) else $error("pin enable off its term");
  a_reg_path: assert property (
    !CFG[1] && run && !terms.clear ##1 !terms.clear
    |=> pin_o == (($past(terms.sum, 2) | $past(terms.preset, 2)) ^ ~CFG[0]))
    else $error("registered pin value wrong");
  a_comb_path: assert property (
    CFG[1] && !$past(rst) |-> pin_o == ($past(terms.sum) ^ ~CFG[0]))
    else $error("combinatorial pin value wrong");
  a_clear_wins: assert property (
    !CFG[1] && terms.clear |=> pin_o == ~CFG[0]) else $error("clear not honoured");
  a_por_clear: assert property (
    !CFG[1] && cnt_q < POR_CYCLES |-> pin_o == ~CFG[0]) else $error("flop not clear");
  a_pin_fb: assert property (
    (CFG[1] || CFG[2]) && cnt_q > 3 |-> fb_o == $past(pin_i, 3))
    else $error("pin feedback wrong");
  a_reg_fb: assert property (
    CFG[2:1] == 2'h0 && cnt_q > 1 |-> fb_o == (pin_o ^ CFG[0]))
    else $error("register feedback wrong");
  a_lock_verify: assert property (
    LOCKED && hsel && hready && htrans[1] && !hwrite && haddr == {28'h0, ADDR_VERIFY}
    |=> hrdata == 32'h0) else $error("verify read while locked");
  a_lock_prog: assert property (
    LOCKED && hsel && hready && htrans[1] && !hwrite && haddr == {28'h0, ADDR_PROG}
    |=> hrdata == 32'h0) else $error("program read while locked");
  c_preset: cover property (!CFG[1] && run && terms.preset && !terms.clear);
  c_clear: cover property (terms.clear && terms.preset);
  c_pin_in: cover property (!pin_oe && fb_o);
endmodule : pom_macrocell_chk
bind pom_macrocell pom_macrocell_chk #(.CFG(CFG), .LOCKED(LOCKED), .POR_CYCLES(POR_CYCLES))
  pom_macrocell_chk_i (.clk(clk), .rst(rst), .terms(terms), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe(pin_oe), .fb_o(fb_o), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata));
`default_nettype wire

// ===== bench/pom_board.sv
// Board logic sharing each macrocell I/O wire
`default_nettype none
module pom_board #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] pin_o,
  input  wire logic [N-1:0] pin_oe,
  input  wire logic [N-1:0] drv_en,
  input  wire logic [N-1:0] drv_val,
  output logic      [N-1:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] last_q = '0;
  // No pull on the wire: a floating pin flips each cycle so stale data never reads back
  always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & drv_en & drv_val)
                    | (~pin_oe & ~drv_en & ~last_q);
  always_ff @(posedge clk) last_q <= pin_i;
endmodule : pom_board
`default_nettype wire

// ===== bench/pom_macrocell_tb.sv
// Bench for six macrocell builds on one register bus
`default_nettype none
module pom_macrocell_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pom_pkg::*;
  localparam int         N = 6;
  // One build per configuration row so every output mode is exercised
  localparam logic [2:0] CFGS [N] = '{3'h0, 3'h3, 3'h5, 3'h1, 3'h6, 3'h4};
  localparam logic       LOCKS [N] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  pom_terms_t  terms = '0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [N-1:0] drv_en = '0;
  logic [N-1:0] drv_val = '0;
  logic [N-1:0] pin_o, pin_oe, fb_o, pin_i, rdy, resp;
  logic [31:0] hrdata [N];
  logic [31:0] rd_q [N];
  logic        rdy_q;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #10 clk = ~clk;
  for (genvar i = 0; i < N; i++) begin : g_mc
    pom_macrocell #(.CFG(CFGS[i]), .LOCKED(LOCKS[i]), .POR_CYCLES(4)) pom_macrocell_i (
      .clk(clk), .rst(rst), .terms(terms), .clock_or_input_pin(clk), .pin_i(pin_i[i]),
      .pin_o(pin_o[i]), .pin_oe(pin_oe[i]), .fb_o(fb_o[i]), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy[0]),
      .hreadyout(rdy[i]), .hresp(resp[i]), .hrdata(hrdata[i]));
  end
  pom_board #(.N(N)) pom_board_i (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .drv_en(drv_en), .drv_val(drv_val), .pin_i(pin_i));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // Bus samples taken at the edge itself, so later updates cannot race them
  always @(posedge clk) begin
    rd_q <= hrdata;
    rdy_q <= rdy[0];
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {28'h0, a};
    do tick(1); while (rdy_q !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do tick(1); while (rdy_q !== 1'b1);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e [N]);
    bus(1'b0, a, 32'h0);
    foreach (e[i]) chk(rd_q[i] & m, e[i]);
  endtask : rd
  initial begin
    tick(20);
    rst <= 1'b0;
    rd(ADDR_STATUS, 32'h31, '{32'h20, 32'h0, 32'h20, 32'h20, 32'h20, 32'h20});
    chk({26'h0, pin_o}, 32'h31);
    tick(4);
    rd(ADDR_STATUS, 32'h31, '{32'h30, 32'h10, 32'h30, 32'h30, 32'h30, 32'h30});
    $display("test power-up done");
    terms <= '{sum: 1'b1, oe: 1'b1, preset: 1'b0, clear: 1'b0};
    tick(3);
    chk({26'h0, pin_o}, 32'h0e);
    chk({26'h0, pin_oe}, 32'h3f);
    terms <= '{sum: 1'b0, oe: 1'b1, preset: 1'b1, clear: 1'b0};
    tick(3);
    chk({26'h0, pin_o}, 32'h1c);
    terms <= '{sum: 1'b0, oe: 1'b1, preset: 1'b1, clear: 1'b1};
    tick(3);
    chk({26'h0, pin_o}, 32'h31);
    chk({30'h0, fb_o[3], fb_o[0]}, 32'h3);
    $display("test data path done");
    terms <= '0;
    drv_en <= 6'h3f;
    drv_val <= 6'h36;
    tick(5);
    chk({26'h0, pin_oe}, 32'h0);
    chk({26'h0, fb_o}, 32'h3f);
    drv_val <= 6'h09;
    tick(5);
    chk({26'h0, fb_o}, 32'h09);
    $display("test feedback done");
    bus(1'b1, ADDR_PROG, 32'h00a5_5a3c);
    rd(ADDR_PROG, '1, '{32'h0, 32'h00a5_5a3c, 32'h0, 32'h0, 32'h0, 32'h0});
    rd(ADDR_VERIFY, '1, '{32'h0, 32'ha55a_3c03, 32'h0, 32'h0, 32'h0, 32'h0});
    rd(ADDR_REFUSE, 32'h3, '{32'h3, 32'h0, 32'h3, 32'h3, 32'h3, 32'h3});
    bus(1'b1, ADDR_REFUSE, 32'h1);
    rd(ADDR_REFUSE, 32'h3, '{32'h2, 32'h0, 32'h2, 32'h2, 32'h2, 32'h2});
    rd(4'h2, '1, '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0});
    chk({26'h0, resp}, 32'h0);
    $display("test registers done");
    end_sim();
  end
endmodule : pom_macrocell_tb
`default_nettype wire
